// [inc/lbw_pkg.sv]
// shared constants and types for the low-power dram burst write path
`default_nettype none
package lbw_pkg;
    localparam int          CA_W          = 6;
    localparam int          DQ_W          = 16;
    // write command first half: cs high, ca = write encoding
    localparam logic [5:0]  CMD_WRITE1    = 6'h04;
    localparam logic [5:0]  CMD_CAS2      = 6'h12;
    localparam logic [5:0]  CMD_READ1     = 6'h02;
    localparam logic [5:0]  CMD_PRECHARGE = 6'h10;
    localparam int          CA_C2_BIT     = 4;
    localparam int          CA_C3_BIT     = 5;
    localparam int          CA_BL_BIT     = 5;
    localparam int          WL_SET_BIT    = 6;
    localparam int          WPST_BIT      = 1;
    localparam int          BL_SHORT      = 16;
    localparam int          BL_LONG       = 32;
    localparam int          PRE_CLOCKS    = 2;
    localparam logic [4:0]  WL_SET_A      = 5'h04;
    localparam logic [4:0]  WL_SET_B      = 5'h04;
    localparam logic [4:0]  NWR_DEFAULT   = 5'h06;
    localparam logic [4:0]  NWTR_DEFAULT  = 5'h04;
    localparam int          CMD_TIMEOUT   = 8;

    typedef struct packed {
        logic             cs;
        logic [CA_W-1:0]  ca;
    } lbw_cmd_t;

    typedef struct packed {
        logic             last;
        logic [DQ_W-1:0]  data;
    } lbw_beat_t;

    typedef enum logic [2:0] {
        LBW_IDLE,
        LBW_CAS,
        LBW_LAT,
        LBW_PRE,
        LBW_DATA,
        LBW_POST
    } lbw_state_t;
endpackage
`default_nettype wire

// [src/lbw_sync.sv]
// three-stage pin synchroniser; change accepted when stages two and three agree
`default_nettype none
module lbw_sync
    import lbw_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             i_clk,
    input  wire logic             i_reset_n,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_sync;

    initial
    begin
        if (WIDTH < 1) $error("width must be positive");
    end

    assign next_sync = (stage2 == stage3) ? stage3 : o_sync;

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            meta   <= '0;
            stage2 <= '0;
            stage3 <= '0;
            o_sync <= '0;
        end
        else
        begin
            meta   <= i_async;
            stage2 <= meta;
            stage3 <= stage2;
            o_sync <= next_sync;
        end
    end
endmodule
`default_nettype wire

// [src/lbw_fifo.sv]
// small valid/ready fifo holding captured write beats
`default_nettype none
module lbw_fifo
    import lbw_pkg::*;
#(
    parameter int WIDTH = 17,
    parameter int DEPTH = 4
)
(
    input  wire logic             i_clk,
    input  wire logic             i_reset_n,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    initial
    begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("depth must be a power of two");
    end

    assign o_in_ready  = (count != (AW+1)'(DEPTH));
    assign o_out_valid = (count != '0);
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;
    assign o_out_data  = mem[rd_ptr];

    always_ff @(posedge i_clk)
    begin
        if (push) mem[wr_ptr] <= i_in_data;
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
            rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
            count  <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// [src/lbw_write_path.sv]
// write-burst capture path of the dram: command decode, latency, strobe capture, recovery
`default_nettype none
module lbw_write_path
    import lbw_pkg::*;
#(
    parameter int DEPTH = 4
)
(
    input  wire logic              i_clk,
    input  wire logic              i_reset_n,
    input  wire logic              i_ck,
    input  wire logic              i_cs,
    input  wire logic [CA_W-1:0]   i_ca,
    input  wire logic              i_dqs,
    input  wire logic [DQ_W-1:0]   i_dq,
    input  wire logic [7:0]        i_mr2,
    input  wire logic [7:0]        i_mr3,
    input  wire logic [4:0]        i_nwr,
    input  wire logic [4:0]        i_nwtr,
    output logic                   o_beat_valid,
    input  wire logic              i_beat_ready,
    output logic [DQ_W-1:0]        o_beat_data,
    output logic                   o_beat_last,
    output logic [5:0]             o_column,
    output logic                   o_busy,
    output logic                   o_wr_recovery,
    output logic                   o_wtr_wait,
    output logic                   o_pre_early,
    output logic                   o_rd_early,
    output logic                   o_overflow
);
    lbw_cmd_t   cmd_s;
    lbw_cmd_t   cmd_raw;
    logic       ck_s;
    logic       ck_d;
    logic       dqs_s;
    logic       dqs_d;
    logic [DQ_W-1:0] dq_s;
    lbw_state_t state;
    lbw_state_t next_state;
    logic [5:0] cnt;
    logic [5:0] beats;
    logic [5:0] burst_len;
    logic       long_post;
    logic [5:0] wr_cnt;
    logic [5:0] wtr_cnt;
    logic       fifo_ready;
    lbw_beat_t  fifo_in;
    lbw_beat_t  fifo_out;

    // sampled pins
    assign cmd_raw = '{cs: i_cs, ca: i_ca};
    lbw_sync #(.WIDTH(1)) u_ck (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_async(i_ck), .o_sync(ck_s));
    lbw_sync #(.WIDTH(1)) u_dqs (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_async(i_dqs), .o_sync(dqs_s));
    lbw_sync #(.WIDTH(CA_W+1)) u_cmd (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_async(cmd_raw), .o_sync(cmd_s));
    lbw_sync #(.WIDTH(DQ_W)) u_dq (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_async(i_dq), .o_sync(dq_s));

    logic ck_rise;
    logic dqs_edge;
    logic dqs_rise;
    logic is_wr1;
    logic is_cas2;
    logic is_rd1;
    logic is_pre;
    logic [4:0] wl;
    logic burst_done;
    logic [5:0] lat_end;
    logic       wr_window;
    logic [5:0] wr_load;
    logic [5:0] wtr_load;

    // latency set must leave room for the preamble clocks before the data window
    initial
    begin
        if (int'(WL_SET_A) <= PRE_CLOCKS || int'(WL_SET_B) <= PRE_CLOCKS)
            $error("write latency too short for preamble");
        if (DEPTH < 2)
            $error("beat fifo depth must be at least two");
    end

    assign ck_rise   = ck_s && !ck_d;
    assign dqs_edge  = dqs_s != dqs_d;
    assign dqs_rise  = dqs_s && !dqs_d;
    assign is_wr1    = ck_rise && cmd_s.cs && (cmd_s.ca[4:0] == CMD_WRITE1[4:0]);
    assign is_cas2   = ck_rise && cmd_s.cs && (cmd_s.ca[4:0] == CMD_CAS2[4:0]);
    assign is_rd1    = ck_rise && cmd_s.cs && (cmd_s.ca[4:0] == CMD_READ1[4:0]);
    assign is_pre    = ck_rise && cmd_s.cs && (cmd_s.ca[4:0] == CMD_PRECHARGE[4:0]);
    assign wl        = i_mr2[WL_SET_BIT] ? WL_SET_B : WL_SET_A;
    assign burst_done = dqs_edge && (beats == burst_len - 6'h01);
    assign lat_end    = 6'(wl) - 6'(PRE_CLOCKS) - 6'h01;
    // write in flight up to the edge where recovery starts; the counters cover the rest
    assign wr_window  = (state != LBW_IDLE) && !(state == LBW_POST && cnt != 6'h00);
    // the load edge is itself the first recovery clock, so one less is left
    assign wr_load    = (i_nwr == 5'h00) ? 6'h00 : 6'(i_nwr) - 6'h01;
    assign wtr_load   = (i_nwtr == 5'h00) ? 6'h00 : 6'(i_nwtr) - 6'h01;

    // data window opens on the wl reference edge; the two clocks before it are preamble
    // opening there leaves room for an early first latching edge within the offset range
    always_comb
    begin
        next_state = state;
        case (state)
            LBW_IDLE: if (is_wr1) next_state = LBW_CAS;
            // non-cas commands in between are tolerated
            LBW_CAS:  if (is_cas2) next_state = LBW_LAT;
            LBW_LAT:  if (ck_rise && cnt == lat_end) next_state = LBW_PRE;
            // strobe ignored through the preamble until the data window opens
            LBW_PRE:  if (ck_rise && cnt == 6'(PRE_CLOCKS) - 6'h01)
                          next_state = LBW_DATA;
            LBW_DATA: if (burst_done) next_state = LBW_POST;
            LBW_POST: if (ck_rise && cnt == (long_post ? 6'h02 : 6'h01))
                          next_state = LBW_IDLE;
            default:  next_state = LBW_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            ck_d <= 1'b0;
            dqs_d <= 1'b0;
            state <= LBW_IDLE;
            cnt <= '0;
            beats <= '0;
            burst_len <= 6'(BL_SHORT);
            long_post <= 1'b0;
            o_column <= '0;
        end
        else
        begin
            ck_d  <= ck_s;
            dqs_d <= dqs_s;
            state <= next_state;
            cnt   <= (next_state != state) ? 6'h00 : (ck_rise ? cnt + 6'h01 : cnt);
            if (is_wr1)
            begin
                burst_len <= cmd_s.ca[CA_BL_BIT] ? 6'(BL_LONG) : 6'(BL_SHORT);
                long_post <= i_mr3[WPST_BIT];
            end
            // all column bits forced to zero by the 6'h00 mask, c3 and c2 included
            if (state == LBW_CAS && is_cas2)
                o_column <= {cmd_s.ca[CA_C3_BIT], cmd_s.ca[CA_C2_BIT], 4'h0} & 6'h00;
            if (state == LBW_DATA && dqs_edge)
                beats <= beats + 6'h01;
            else if (state != LBW_DATA)
                beats <= '0;
        end
    end

    // beats are taken on every strobe edge, rising or falling, while in the data window
    assign fifo_in = '{last: burst_done, data: dq_s};
    lbw_fifo #(.WIDTH(DQ_W+1), .DEPTH(DEPTH)) u_fifo (
        .i_clk      (i_clk),
        .i_reset_n  (i_reset_n),
        .i_in_valid (state == LBW_DATA && dqs_edge),
        .o_in_ready (fifo_ready),
        .i_in_data  (fifo_in),
        .o_out_valid(o_beat_valid),
        .i_out_ready(i_beat_ready),
        .o_out_data (fifo_out)
    );
    assign o_beat_data = fifo_out.data;
    assign o_beat_last = fifo_out.last;
    assign o_busy      = state != LBW_IDLE;

    // recovery and write-to-read windows open at first clock after last edge
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            wr_cnt <= '0;
            wtr_cnt <= '0;
            o_overflow <= 1'b0;
            o_pre_early <= 1'b0;
            o_rd_early <= 1'b0;
        end
        else
        begin
            if (state == LBW_POST && cnt == 6'h00 && ck_rise)
            begin
                wr_cnt  <= wr_load;
                wtr_cnt <= wtr_load;
            end
            else if (ck_rise)
            begin
                wr_cnt  <= (wr_cnt != '0) ? wr_cnt - 6'h01 : wr_cnt;
                wtr_cnt <= (wtr_cnt != '0) ? wtr_cnt - 6'h01 : wtr_cnt;
            end
            o_overflow  <= (state == LBW_DATA && dqs_edge && !fifo_ready) || o_overflow;
            o_pre_early <= is_pre && (wr_window || wr_cnt != '0);
            o_rd_early  <= is_rd1 && (wr_window || wtr_cnt != '0);
        end
    end
    assign o_wr_recovery = wr_cnt != '0;
    assign o_wtr_wait    = wtr_cnt != '0;

    chk_burst_ends: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (state == LBW_DATA && burst_done) |=> state == LBW_POST)
        else $error("burst did not end after last beat");
    chk_recovery_load: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (state == LBW_POST && cnt == 6'h00 && ck_rise)
            |=> wr_cnt == ((i_nwr == 5'h00) ? 6'h00 : 6'(i_nwr) - 6'h01))
        else $error("recovery not started");
    chk_wtr_load: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (state == LBW_POST && cnt == 6'h00 && ck_rise)
            |=> wtr_cnt == ((i_nwtr == 5'h00) ? 6'h00 : 6'(i_nwtr) - 6'h01))
        else $error("write-to-read not started");
    chk_post_sel: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        is_wr1 |=> long_post == $past(i_mr3[WPST_BIT]))
        else $error("postamble select wrong");
    chk_wl_sel: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (state == LBW_LAT && next_state == LBW_PRE)
            |-> cnt == (i_mr2[WL_SET_BIT] ? 6'(WL_SET_B) : 6'(WL_SET_A)) - 6'(PRE_CLOCKS) - 6'h01)
        else $error("latency set wrong");
    chk_column_zero: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_column[1:0] == 2'b00)
        else $error("column not aligned");
    chk_pre_flag: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (is_pre && (state == LBW_DATA || wr_cnt != '0)) |=> o_pre_early)
        else $error("early precharge not flagged");
    chk_rd_flag: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (is_rd1 && (state == LBW_DATA || wtr_cnt != '0)) |=> o_rd_early)
        else $error("early read not flagged");
    cov_write: cover property (@(posedge i_clk) disable iff (!i_reset_n)
        state == LBW_DATA ##1 state == LBW_POST);
    cov_long_post: cover property (@(posedge i_clk) disable iff (!i_reset_n)
        state == LBW_POST && long_post);
    cov_fifo_full: cover property (@(posedge i_clk) disable iff (!i_reset_n) !fifo_ready);
    cov_pre_early: cover property (@(posedge i_clk) disable iff (!i_reset_n) o_pre_early);
    cov_rd_early: cover property (@(posedge i_clk) disable iff (!i_reset_n) o_rd_early);
endmodule
`default_nettype wire

// [testbench/lbw_host.sv]
// host controller model: link clock, command pins, write strobe and data
`default_nettype none
module lbw_host
    import lbw_pkg::*;
(
    output var logic            o_ck,
    output var logic            o_cs,
    output var logic [CA_W-1:0] o_ca,
    output var logic            o_dqs,
    output var logic [DQ_W-1:0] o_dq
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        o_ck  = 1'b0;
        o_cs  = 1'b0;
        o_ca  = 6'h3F;
        o_dqs = 1'b1;
        o_dq  = 16'h0000;
        #133;
        forever #400 o_ck = ~o_ck;
    end

    // write at rise 0, cas-2 at rise 1, precharge at rise gap, read at gap+1
    task automatic burst(input logic long, input logic ext, input int gap,
                         input logic [DQ_W-1:0] base);
        int n;
        n = long ? BL_LONG : BL_SHORT;
        @(negedge o_ck);
        o_cs = 1'b1;
        o_ca = CMD_WRITE1;
        o_ca[CA_BL_BIT] = long;
        @(negedge o_ck);
        o_ca = CMD_CAS2;
        fork
            begin
                @(negedge o_ck);
                o_cs = 1'b0;
                o_ca = ~o_ca;
                repeat (gap - 2) @(negedge o_ck);
                o_cs = 1'b1;
                o_ca = CMD_PRECHARGE;
                @(negedge o_ck);
                o_ca = CMD_READ1;
                @(negedge o_ck);
                o_cs = 1'b0;
                o_ca = ~o_ca;
            end
            begin
                repeat (2) @(posedge o_ck);
                // stray strobe activity before the preamble
                #200 o_dqs = 1'b0;
                #200 o_dqs = 1'b1;
                repeat (int'(WL_SET_A) - 2) @(posedge o_ck);
                o_dqs = 1'b0;
                @(posedge o_ck);
                #400;
                for (int i = 0; i < n; i++)
                begin
                    #200 o_dq = base + DQ_W'(i);
                    #200 o_dqs = ~o_dqs;
                end
                #200 o_dq = ~o_dq;
                #200;
                if (ext)
                begin
                    o_dqs = 1'b1;
                    #400 o_dqs = 1'b0;
                    #400;
                end
                o_dqs = 1'b1;
            end
        join
    endtask
endmodule
`default_nettype wire

// [testbench/tb.sv]
// self-checking bench for the dram burst write path
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import lbw_pkg::*;

    logic            i_clk, i_reset_n, ck, cs, dqs, i_beat_ready;
    logic [CA_W-1:0] ca;
    logic [DQ_W-1:0] dq, o_beat_data;
    logic [7:0]      i_mr2, i_mr3;
    logic [4:0]      i_nwr, i_nwtr;
    logic [5:0]      o_column;
    logic            o_beat_valid, o_beat_last, o_busy, o_wr_recovery;
    logic            o_wtr_wait, o_pre_early, o_rd_early, o_overflow;
    logic [4:0]      seen;
    lbw_beat_t       got[$];
    int              n_mismatch, checks_done;

    lbw_host host_u (.o_ck(ck), .o_cs(cs), .o_ca(ca), .o_dqs(dqs), .o_dq(dq));

    lbw_write_path #(.DEPTH(4)) dut_u (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_ck(ck), .i_cs(cs), .i_ca(ca),
        .i_dqs(dqs), .i_dq(dq), .i_mr2(i_mr2), .i_mr3(i_mr3), .i_nwr(i_nwr),
        .i_nwtr(i_nwtr), .o_beat_valid(o_beat_valid), .i_beat_ready(i_beat_ready),
        .o_beat_data(o_beat_data), .o_beat_last(o_beat_last), .o_column(o_column),
        .o_busy(o_busy), .o_wr_recovery(o_wr_recovery), .o_wtr_wait(o_wtr_wait),
        .o_pre_early(o_pre_early), .o_rd_early(o_rd_early), .o_overflow(o_overflow));

    always #50 i_clk = ~i_clk;

    // collect accepted beats and remember pulses; mid-cycle sampling avoids the edge race
    always @(negedge i_clk)
    begin
        if (o_beat_valid === 1'b1 && i_beat_ready === 1'b1)
            got.push_back({o_beat_last, o_beat_data});
        seen = seen | {o_busy, o_wr_recovery, o_wtr_wait, o_pre_early, o_rd_early};
    end

    task automatic chk_word(input logic [16:0] got_v, input logic [16:0] exp_v);
        checks_done++;
        if (got_v !== exp_v)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got_v, exp_v);
        end
    endtask

    task automatic chk_bit(input logic got_v, input logic exp_v);
        chk_word({16'h0000, got_v}, {16'h0000, exp_v});
    endtask

    task automatic run(input logic long, input logic ext, input int gap,
                       input logic rdy, input logic [DQ_W-1:0] base);
        @(posedge i_clk);
        #10;
        got.delete();
        seen = '0;
        i_beat_ready = rdy;
        host_u.burst(long, ext, gap, base);
        repeat (60) @(posedge i_clk);
        #10;
    endtask

    task automatic beats_ok(input int n, input logic full, input logic [DQ_W-1:0] base);
        chk_word(17'(got.size()), 17'(n));
        foreach (got[i])
            chk_word(got[i], {full && (i == n - 1), base + DQ_W'(i)});
    endtask

    task automatic sc_plain();
        // precharge one clock short of the limit, read exactly on it
        run(1'b0, 1'b0, 15, 1'b1, 16'hA100);
        beats_ok(BL_SHORT, 1'b1, 16'hA100);
        chk_word(17'(o_column[1:0]), 17'h00000);
        chk_bit(seen[4], 1'b1);
        chk_bit(seen[3], 1'b1);
        chk_bit(seen[2], 1'b1);
        chk_bit(seen[1], 1'b1);
        chk_bit(seen[0], 1'b0);
        chk_bit(o_busy, 1'b0);
    endtask

    task automatic sc_early();
        run(1'b0, 1'b0, 12, 1'b1, 16'hB200);
        beats_ok(BL_SHORT, 1'b1, 16'hB200);
        chk_bit(seen[1], 1'b1);
        chk_bit(seen[0], 1'b1);
    endtask

    task automatic sc_long();
        i_mr2[WL_SET_BIT] = 1'b1;
        i_mr3[WPST_BIT] = 1'b1;
        run(1'b1, 1'b1, 30, 1'b1, 16'hC300);
        beats_ok(BL_LONG, 1'b1, 16'hC300);
        chk_bit(seen[1], 1'b0);
        i_mr2 = 8'h00;
        i_mr3 = 8'h00;
    endtask

    task automatic sc_full();
        run(1'b0, 1'b0, 20, 1'b0, 16'hD400);
        chk_bit(o_overflow, 1'b1);
        i_beat_ready = 1'b1;
        repeat (20) @(posedge i_clk);
        #10;
        beats_ok(4, 1'b0, 16'hD400);
        chk_bit(o_beat_valid, 1'b0);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        i_clk = 1'b0;
        i_reset_n = 1'b0;
        i_mr2 = 8'h00;
        i_mr3 = 8'h00;
        i_nwr = 5'h02;
        i_nwtr = 5'h02;
        i_beat_ready = 1'b1;
        seen = '0;
        n_mismatch = 0;
        checks_done = 0;
        repeat (6) @(posedge i_clk);
        #10;
        i_reset_n = 1'b1;
        chk_bit(o_overflow, 1'b0);
        sc_plain();
        sc_early();
        sc_long();
        sc_full();
        tally_and_finish();
    end

    // cut a hang short well after the four bursts should be over
    initial
    begin
        #2000000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
